// [rtl/video_pixel_unpacker.sv]
// video memory to pixel unpacker for text and three graphics modes
module video_pixel_unpacker
  import pixel_unpack_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // mode control
  input wire video_mode_t mode,
  input wire logic text_wide,
  input wire logic mono_panel,
  input wire logic [1:0] font_sel,
  input wire logic [3:0] bg_color,
  // scan timing
  input wire logic frame_start,
  input wire scan_pos_t pos,
  input wire logic pix_en,
  // video memory, one cycle read latency
  output logic vram_rd,
  output logic [VRAM_AW-1:0] vram_addr,
  input wire logic [7:0] vram_data,
  // character generator, one cycle read latency
  output logic font_rd,
  output logic [FONT_AW-1:0] font_addr,
  input wire logic [7:0] font_data,
  // pixel output
  output pixel_out_t pixel
);

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_FETCH = 8'b0000_0010,
    ST_WAIT  = 8'b0000_0100,
    ST_DATA  = 8'b0000_1000,
    ST_ATTR  = 8'b0001_0000,
    ST_FWAIT = 8'b0010_0000,
    ST_GLYPH = 8'b0100_0000,
    ST_SHIFT = 8'b1000_0000
  } fetch_state_t;

  ////////////////////////////////////////////////////////////////////////
  // address generation

  logic [1:0] block_sel;
  logic row_adv;
  logic [VRAM_AW-1:0] block_size;
  logic [VRAM_AW-1:0] stride;
  logic [VRAM_AW-1:0] gen_addr;
  logic byte_step;
  logic [3:0] glyph_row;

  always_comb begin
    block_sel = 2'd0;
    // a text row spans sixteen glyph lines
    row_adv = (pos.line[3:0] == 4'h0);
    block_size = BLOCK_SIZE_2;
    stride = text_wide ? STRIDE_TEXT80 : STRIDE_TEXT40;
    glyph_row = pos.line[3:0];
    case (mode)
      MODE_G320: begin
        block_sel = {1'b0, pos.line[0]};
        row_adv = !pos.line[0];
        stride = STRIDE_G320;
      end
      MODE_G640: begin
        block_sel = {1'b0, pos.line[0]};
        row_adv = !pos.line[0];
        stride = STRIDE_G640;
      end
      MODE_G400: begin
        block_sel = pos.line[1:0];
        row_adv = (pos.line[1:0] == 2'd0);
        block_size = BLOCK_SIZE_4;
        stride = STRIDE_G640;
      end
      default: begin
      end
    endcase
  end

  line_addr_gen u_addr (
    .clk(clk),
    .reset(reset),
    .frame_start(frame_start),
    .line_start(pos.line_start),
    .byte_step(byte_step),
    .row_adv(row_adv),
    .block_size(block_size),
    .stride(stride),
    .block_sel(block_sel),
    .addr(gen_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // fetch sequencer

  fetch_state_t st_reg;
  fetch_state_t st_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  char_cell_t cell_reg;
  char_cell_t cell_next;
  logic [7:0] fetched;
  logic load;
  logic vram_rd_next;
  logic font_rd_next;
  logic [FONT_AW-1:0] font_addr_next;
  logic [2:0] last_cnt;

  assign last_cnt = (mode == MODE_G320) ? 3'd3 : 3'd7;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cell_next = cell_reg;
    fetched = 8'h00;
    byte_step = 1'b0;
    load = 1'b0;
    vram_rd_next = 1'b0;
    font_rd_next = 1'b0;
    font_addr_next = font_addr;
    if (frame_start || pos.line_start) begin
      st_next = ST_FETCH;
      cnt_next = 3'd0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
        end
        // strobe and address leave together, so the byte pointer moves on as each read goes out
        ST_FETCH: begin
          vram_rd_next = 1'b1;
          byte_step = 1'b1;
          st_next = ST_WAIT;
        end
        // memory answers two edges after the strobe is decided, so text issues its attribute read here
        ST_WAIT: begin
          if (mode == MODE_TEXT) begin
            vram_rd_next = 1'b1;
            byte_step = 1'b1;
          end
          st_next = ST_DATA;
        end
        ST_DATA: begin
          if (mode == MODE_TEXT) begin
            cell_next.code = vram_data;
            st_next = ST_ATTR;
          end else begin
            fetched = vram_data;
            load = 1'b1;
            st_next = ST_SHIFT;
          end
        end
        ST_ATTR: begin
          cell_next.attr = vram_data;
          font_rd_next = 1'b1;
          // font, intensity, code and glyph row form the generator address
          font_addr_next = {font_sel, vram_data[3], cell_reg.code, glyph_row};
          st_next = ST_FWAIT;
        end
        ST_FWAIT: begin
          st_next = ST_GLYPH;
        end
        ST_GLYPH: begin
          fetched = font_data;
          load = 1'b1;
          st_next = ST_SHIFT;
        end
        ST_SHIFT: begin
          if (pix_en) begin
            cnt_next = cnt_reg + 3'd1;
            if (cnt_reg == last_cnt) begin
              cnt_next = 3'd0;
              vram_rd_next = 1'b1;
              byte_step = 1'b1;
              st_next = ST_WAIT;
            end
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 3'd0;
      cell_reg <= '0;
      vram_rd <= 1'b0;
      vram_addr <= '0;
      font_rd <= 1'b0;
      font_addr <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cell_reg <= cell_next;
      vram_rd <= vram_rd_next;
      vram_addr <= gen_addr;
      font_rd <= font_rd_next;
      font_addr <= font_addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pixel serialiser and colour

  logic [1:0] pix;
  logic two_bit;
  assign two_bit = (mode == MODE_G320);

  // the byte is loaded as it arrives, so the first pixel is ready on entry to shifting
  pixel_shifter u_shift (
    .clk(clk),
    .reset(reset),
    .load(load),
    .load_byte(fetched),
    .two_bit(two_bit),
    .shift(pix_en & (st_reg == ST_SHIFT)),
    .pix(pix)
  );

  pixel_out_t pixel_next;
  logic underline;

  always_comb begin
    // underline is defined only for the monochrome panel path
    underline = mono_panel && (cell_reg.attr[2:0] == UNDERLINE_FG) && (glyph_row == UNDERLINE_ROW);
    pixel_next = '0;
    pixel_next.valid = pix_en && (st_reg == ST_SHIFT);
    case (mode)
      MODE_TEXT: begin
        if (pix[0] || underline) begin
          pixel_next.color = cell_reg.attr[3:0];
          pixel_next.mono = 1'b1;
        end else begin
          pixel_next.color = cell_reg.attr[7:4];
        end
      end
      MODE_G320: begin
        pixel_next.color = (pix == 2'b00) ? bg_color : {2'b00, pix};
        pixel_next.mono = (pix != 2'b00);
      end
      MODE_G640, MODE_G400: begin
        pixel_next.color = {4{pix[0]}};
        pixel_next.mono = pix[0];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pixel <= '0;
    end else begin
      pixel <= pixel_next;
    end
  end

endmodule // video_pixel_unpacker

// [common/pixel_unpack_pkg.sv]
// package: modes, memory layout, font layout and carriers for the pixel unpacker
package pixel_unpack_pkg;

  typedef enum logic [3:0] {
    MODE_TEXT = 4'b0001,
    MODE_G320 = 4'b0010,
    MODE_G640 = 4'b0100,
    MODE_G400 = 4'b1000
  } video_mode_t;

  localparam int VRAM_AW = 15;
  localparam int FONT_AW = 15;
  localparam int FONT_COUNT = 4;
  localparam int FONT_ROWS = 16;
  localparam int CHAR_W = 8;
  localparam int CELL_BYTES = 2;
  localparam logic [VRAM_AW-1:0] BLOCK_SIZE_2 = 15'h2000;
  localparam logic [VRAM_AW-1:0] BLOCK_SIZE_4 = 15'h2000;
  localparam logic [VRAM_AW-1:0] STRIDE_TEXT80 = 15'h00a0;
  localparam logic [VRAM_AW-1:0] STRIDE_TEXT40 = 15'h0050;
  localparam logic [VRAM_AW-1:0] STRIDE_G320 = 15'h0050;
  localparam logic [VRAM_AW-1:0] STRIDE_G640 = 15'h0050;
  localparam logic [2:0] UNDERLINE_FG = 3'h1;
  localparam logic [3:0] UNDERLINE_ROW = 4'hd;
  localparam int FONT_SEL_LSB = 13;
  localparam int INTENS_BIT = 12;
  localparam int CODE_LSB = 4;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] attr;
  } char_cell_t;

  typedef struct packed {
    logic valid;
    logic [3:0] color;
    logic mono;
  } pixel_out_t;

  typedef struct packed {
    logic line_start;
    logic [9:0] line;
    logic [9:0] col;
  } scan_pos_t;

endpackage : pixel_unpack_pkg

// [rtl/pixel_shifter.sv]
// byte shifter that emits pixels msb first at one or two bits each
module pixel_shifter
  import pixel_unpack_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // load side
  input wire logic load,
  input wire logic [7:0] load_byte,
  input wire logic two_bit,
  // pixel side
  input wire logic shift,
  output logic [1:0] pix
);

  logic [7:0] sh_reg;
  logic [7:0] sh_next;

  always_comb begin
    sh_next = sh_reg;
    if (load) begin
      sh_next = load_byte;
    end else if (shift) begin
      sh_next = two_bit ? {sh_reg[5:0], 2'b00} : {sh_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sh_reg <= 8'h00;
    end else begin
      sh_reg <= sh_next;
    end
  end

  // leftmost pixel always comes from the top of the byte
  assign pix = two_bit ? sh_reg[7:6] : {1'b0, sh_reg[7]};

endmodule // pixel_shifter

// [rtl/line_addr_gen.sv]
// line base and byte address generator for interleaved memory blocks
module line_addr_gen
  import pixel_unpack_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // scan control
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic byte_step,
  input wire logic row_adv,
  input wire logic [VRAM_AW-1:0] block_size,
  input wire logic [VRAM_AW-1:0] stride,
  input wire logic [1:0] block_sel,
  // address
  output logic [VRAM_AW-1:0] addr
);

  logic [VRAM_AW-1:0] row_base_reg;
  logic [VRAM_AW-1:0] row_base_next;
  logic [VRAM_AW-1:0] offs_reg;
  logic [VRAM_AW-1:0] offs_next;
  logic first_reg;
  logic first_next;

  // every line restarts the byte offset; the row base moves only on row_adv,
  // and never on the first line of a frame, which always sits at row zero
  always_comb begin
    row_base_next = row_base_reg;
    offs_next = offs_reg;
    first_next = first_reg;
    if (frame_start) begin
      row_base_next = '0;
      offs_next = '0;
      first_next = 1'b1;
    end else if (line_start) begin
      first_next = 1'b0;
      if (row_adv && !first_reg) begin
        row_base_next = row_base_reg + stride;
      end
      offs_next = '0;
    end else if (byte_step) begin
      offs_next = offs_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      row_base_reg <= '0;
      offs_reg <= '0;
      first_reg <= 1'b1;
    end else begin
      row_base_reg <= row_base_next;
      offs_reg <= offs_next;
      first_reg <= first_next;
    end
  end

  // block base is block index times block size
  assign addr = VRAM_AW'(block_size * VRAM_AW'(block_sel)) + row_base_reg + offs_reg;

endmodule // line_addr_gen

// [dv/video_pixel_unpacker_sva.sv]
// port checker for the pixel unpacker
module video_pixel_unpacker_sva
  import pixel_unpack_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire video_mode_t mode,
  input wire logic [1:0] font_sel,
  input wire scan_pos_t pos,
  input wire logic pix_en,
  // memory and pixels
  input wire logic vram_rd,
  input wire logic [VRAM_AW-1:0] vram_addr,
  input wire logic font_rd,
  input wire logic [FONT_AW-1:0] font_addr,
  input wire pixel_out_t pixel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !vram_rd && !font_rd && !pixel.valid)
    else $error("output active in reset");
  a_font_text: assert property (font_rd |-> mode == MODE_TEXT)
    else $error("glyph read outside text");
  a_font_bank: assert property (font_rd |-> font_addr[14:13] == font_sel)
    else $error("font bank wrong");
  a_glyph_row: assert property (pos.line_start && mode == MODE_TEXT |->
    ##5 font_rd && font_addr[3:0] == $past(pos.line[3:0], 5))
    else $error("glyph row wrong");
  a_cell_even: assert property (pos.line_start && mode == MODE_TEXT |-> ##2 vram_rd && !vram_addr[0])
    else $error("cell not even");
  a_block_two: assert property (pos.line_start && (mode == MODE_G320 || mode == MODE_G640) |->
    ##2 vram_rd && vram_addr[14:13] == {1'b0, $past(pos.line[0], 2)})
    else $error("two block select wrong");
  a_block_four: assert property (pos.line_start && mode == MODE_G400 |->
    ##2 vram_rd && vram_addr[14:13] == $past(pos.line[1:0], 2))
    else $error("four block select wrong");
  a_pixel_paced: assert property (pixel.valid |-> $past(pix_en))
    else $error("pixel without enable");
  c_glyph: cover property (font_rd);
  c_four: cover property (mode == MODE_G400 && vram_rd);
  c_pix: cover property (pixel.valid && mode == MODE_G320);
endmodule // video_pixel_unpacker_sva

// [dv/mem_model.sv]
// read memory, one cycle latency, contents hashed from the address
module mem_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic rd,
  input wire logic [14:0] addr,
  input wire logic [7:0] salt,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] junk = 8'h3c;
  // between reads the bus wanders so stale data never looks valid
  always @(posedge clk) begin
    junk <= junk + 8'h25;
    data <= rd ? (addr[7:0] ^ addr[14:7] ^ salt) : junk;
  end
endmodule // mem_model

// [dv/video_memory_pixel_unpacker_tb.sv]
// bench: fetch order, blocks, strides and glyph lookup
module video_memory_pixel_unpacker_tb
  import pixel_unpack_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  video_mode_t mode = MODE_TEXT;
  logic text_wide = 1'b0, mono_panel = 1'b0, frame_start = 1'b0, pix_en = 1'b1;
  logic [1:0] font_sel = 2'h0;
  logic [3:0] bg_color = 4'h0;
  scan_pos_t pos = '0;
  logic vram_rd, font_rd;
  logic [14:0] vram_addr, font_addr;
  logic [7:0] vram_data, font_data, salt = 8'h00;
  pixel_out_t pixel;
  logic [14:0] vq[$], fq[$];
  pixel_out_t pq[$];
  logic [31:0] rng = 32'h0000_922d;
  int errors = 0, checks_done = 0, cyc = 0;
  video_mode_t modes[5] = '{MODE_TEXT, MODE_G320, MODE_G640, MODE_G400, MODE_TEXT};
  ////////////////////////////////////////
  video_pixel_unpacker dut_u (.clk(clk), .reset(reset), .mode(mode), .text_wide(text_wide),
    .mono_panel(mono_panel), .font_sel(font_sel), .bg_color(bg_color), .frame_start(frame_start),
    .pos(pos), .pix_en(pix_en), .vram_rd(vram_rd), .vram_addr(vram_addr), .vram_data(vram_data),
    .font_rd(font_rd), .font_addr(font_addr), .font_data(font_data), .pixel(pixel));
  mem_model vram_u (.clk(clk), .rd(vram_rd), .addr(vram_addr), .salt(salt), .data(vram_data));
  mem_model font_u (.clk(clk), .rd(font_rd), .addr(font_addr), .salt(salt), .data(font_data));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (vram_rd) vq.push_back(vram_addr);
    if (font_rd) fq.push_back(font_addr);
    if (pixel.valid) pq.push_back(pixel);
    if (cyc == 30000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [7:0] mem_val(logic [14:0] a);
    return a[7:0] ^ a[14:7] ^ salt;
  endfunction
  function automatic logic [14:0] base(int l);
    case (mode)
      MODE_TEXT: return 15'(l / 16) * (text_wide ? STRIDE_TEXT80 : STRIDE_TEXT40);
      MODE_G400: return 15'(l % 4) * BLOCK_SIZE_4 + 15'(l / 4) * STRIDE_G640;
      MODE_G320: return 15'(l % 2) * BLOCK_SIZE_2 + 15'(l / 2) * STRIDE_G320;
      default: return 15'(l % 2) * BLOCK_SIZE_2 + 15'(l / 2) * STRIDE_G640;
    endcase
  endfunction
  // first pixels of a line: text from glyph and attribute, graphics from the first byte
  function automatic pixel_out_t exp_pix(int l, int i);
    logic [7:0] g;
    logic [7:0] at;
    logic [1:0] v;
    logic on;
    pixel_out_t p;
    g = mem_val(base(l));
    at = mem_val(base(l) + 15'h0001);
    p = '0;
    p.valid = 1'b1;
    case (mode)
      MODE_TEXT: begin
        g = mem_val({font_sel, at[3], g, 4'(l)});
        on = g[7 - i] || (mono_panel && at[2:0] == UNDERLINE_FG && 4'(l) == UNDERLINE_ROW);
        p.color = on ? at[3:0] : at[7:4];
        p.mono = on;
      end
      MODE_G320: begin
        v = g[7 - 2 * i -: 2];
        p.color = (v == 2'b00) ? bg_color : {2'b00, v};
        p.mono = (v != 2'b00);
      end
      default: begin
        p.color = {4{g[7 - i]}};
        p.mono = g[7 - i];
      end
    endcase
    return p;
  endfunction
  task automatic cmp_pix(input pixel_out_t got, input pixel_out_t exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t pixel got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // pixels of the old line still land one cycle after the restart, so queues clear a cycle later
  task automatic run_line(input int l);
    logic [14:0] b;
    logic [7:0] at;
    int n;
    b = base(l);
    at = mem_val(b + 15'h0001);
    n = (mode == MODE_G320) ? 4 : 8;
    pos.line = 10'(l);
    pos.line_start = 1'b1;
    @(negedge clk);
    pos.line_start = 1'b0;
    @(negedge clk);
    vq.delete();
    fq.delete();
    pq.delete();
    for (int i = 0; i < 80 && vq.size() < 3; i++) @(negedge clk);
    while (vq.size() < 3) vq.push_back('x);
    if (fq.size() == 0) fq.push_back('x);
    while (pq.size() < n) pq.push_back('x);
    for (int i = 0; i < n; i++) cmp_pix(pq[i], exp_pix(l, i));
    cmp(vq[0], b);
    cmp(vq[1], b + 15'h0001);
    if (mode == MODE_TEXT) begin
      cmp(vq[2], b + 15'h0002);
      cmp(fq[0], {font_sel, at[3], mem_val(b), 4'(l)});
    end
  endtask
  initial begin
    foreach (modes[m]) begin
      reset = 1'b1;
      mode = modes[m];
      {font_sel, bg_color, text_wide, mono_panel} = 8'(xs());
      salt = 8'(xs() >> 8);
      if (m == 4) {font_sel, text_wide} = 3'h7;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      for (int l = 0; l < 18; l++) run_line(l);
      $display("mode %b done", mode);
    end
    close_out();
  end
endmodule // video_memory_pixel_unpacker_tb

bind video_pixel_unpacker video_pixel_unpacker_sva chk_u (.clk(clk), .reset(reset), .mode(mode),
  .font_sel(font_sel), .pos(pos), .pix_en(pix_en), .vram_rd(vram_rd), .vram_addr(vram_addr),
  .font_rd(font_rd), .font_addr(font_addr), .pixel(pixel));
